// file: rtl/rc_front_pkg.sv
// Package: constants and types for the command front end
package rc_front_pkg;
    localparam int          CMD_W          = 8;
    localparam int          PW_W           = 16;
    localparam int          ADC_W          = 10;
    localparam logic [7:0]  CMD_MAX        = 8'h7F;
    localparam logic [7:0]  CMD_MIN        = 8'h81;  // -127
    localparam logic [9:0]  ADC_FULL       = 10'h3FF;
    localparam logic [9:0]  ADC_MID        = 10'h200;
    localparam logic [9:0]  ADC_MID_TOL    = 10'h008;
    localparam int          ADC_MID_X254   = 127 * 1023;
    localparam int          CLK_MHZ        = 250;
    localparam int          PERIOD_MS      = 200;
    localparam int          PERIOD_CYC     = PERIOD_MS * 1000 * CLK_MHZ;
    localparam int          N_FIELDS       = 12;
    localparam int          N_CHARS        = 2 * N_FIELDS;
    localparam int          BAUD           = 9600;
    localparam int          BIT_CYC        = CLK_MHZ * 1000000 / BAUD;
    localparam logic [7:0]  FRAME_END      = 8'h0D;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_WAIT = 3'b100
    } tx_state_t;
endpackage

// file: rtl/rc_analog_command_front_end.sv
// Module: radio and analog command shaping with periodic telemetry
// Overview of operation
// - Calibrated min, center, max map to full reverse, zero, full forward.
// - Reverse and forward spans are scaled separately around center.
// - Accessory turns on at channel 3 maximum, off at its center.
// - No channel 3 accessory control when the encoder build is fitted.
// - Radio mode continuously sends twelve values as two hex characters.
// - String carries commands, power, analogs, amps, temps, volts, encoder.
// - Whole string is resent once per 200 ms period with latest data.
// - Analog command: -127 at 0 V, 0 at midpoint, +127 at full scale.
// - Analog command goes through deadband then curve stage before use.
// - Analog mode drives motors independently or mixed, by configuration.
// - Closed loop under analog command only with encoder feedback.
// - After reset in analog mode motors stay inactive until both analog inputs centered.
// - Servo feedback: channel 1 from analog 3, channel 2 from analog 4.
// - Analog mode ignores receive, sends telemetry; switch stops or inverts.
// - Accessory output forced off whenever radio loss is declared.
`timescale 1ns/10ps
module rc_analog_command_front_end
    import rc_front_pkg::*;
#(
    parameter bit ENCODER_FITTED = 1'b0,
    parameter int PERIOD_CYCLES  = PERIOD_CYC,
    parameter int BIT_CYCLES     = BIT_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 analog_mode,
    input  wire logic                 mixed_mode,
    input  wire logic                 closed_loop_req,
    input  wire logic                 switch_is_estop,
    input  wire logic                 switch_in,
    input  wire logic                 radio_lost,
    input  wire logic [PW_W-1:0]      cal_min,
    input  wire logic [PW_W-1:0]      cal_ctr,
    input  wire logic [PW_W-1:0]      cal_max,
    input  wire logic [PW_W-1:0]      pulse1,
    input  wire logic [PW_W-1:0]      pulse2,
    input  wire logic [PW_W-1:0]      pulse3,
    input  wire logic [ADC_W-1:0]     ana1,
    input  wire logic [ADC_W-1:0]     ana2,
    input  wire logic [ADC_W-1:0]     ana3,
    input  wire logic [ADC_W-1:0]     ana4,
    input  wire logic [2:0]           deadband,
    input  wire logic [79:0]          status_fields,
    output logic signed [CMD_W-1:0]   motor_cmd1,
    output logic signed [CMD_W-1:0]   motor_cmd2,
    output logic [ADC_W-1:0]          feedback1,
    output logic [ADC_W-1:0]          feedback2,
    output logic                      motors_enabled,
    output logic                      closed_loop_ok,
    output logic                      accessory_out,
    output logic                      serial_tx
);
    // ******************************************************
    // Functions
    // ******************************************************
    // Pulse width to signed command, sides scaled apart
    function automatic logic [7:0] pulse_to_cmd(input logic [15:0] pw,
            input logic [15:0] lo, input logic [15:0] ce,
            input logic [15:0] hi);
        logic [31:0] num;
        logic [15:0] span;
        num  = 32'h0;
        span = 16'h0;
        if (pw >= hi) begin
            pulse_to_cmd = CMD_MAX;
        end else if (pw <= lo) begin
            pulse_to_cmd = CMD_MIN;
        end else if (pw >= ce) begin
            span = hi - ce;
            num  = 32'(pw - ce) * 32'd127 / 32'(span);
            pulse_to_cmd = num[7:0];
        end else begin
            span = ce - lo;
            num  = 32'(ce - pw) * 32'd127 / 32'(span);
            pulse_to_cmd = 8'(-num[7:0]);
        end
    endfunction

    // Analog code to signed command, linear -127..+127
    function automatic logic [7:0] adc_to_cmd(input logic [9:0] a);
        logic [31:0] t;
        t = 32'(a) * 32'd254;
        if (a >= ADC_FULL) begin
            adc_to_cmd = CMD_MAX;
        end else if (t >= 32'(ADC_MID_X254) * 32'd2 / 32'd2 * 32'd1
                + 32'd0 && t >= 32'(ADC_MID_X254)) begin
            adc_to_cmd = 8'((t - 32'(ADC_MID_X254)) / 32'd1023);
        end else begin
            adc_to_cmd = 8'(-8'((32'(ADC_MID_X254) - t) / 32'd1023));
        end
    endfunction

    // Deadband then square-blend curve, keeps full scale at 127
    function automatic logic [7:0] shape(input logic [7:0] c,
            input logic [2:0] db);
        logic [7:0]  mag;
        logic [7:0]  thr;
        logic [15:0] sc;
        logic [15:0] sq;
        mag = c[7] ? 8'(-c) : c;
        thr = {2'b00, db, 3'b000} >> 1;                     // 0..28 counts
        sc  = 16'h0;
        sq  = 16'h0;
        if (mag <= thr) begin
            shape = 8'h00;
        end else begin
            sc = 16'(mag - thr) * 16'd127 / 16'(8'd127 - thr);
            sq = (sc * sc) / 16'd127;
            sc = (sc + sq) >> 1;
            shape = c[7] ? 8'(-sc[7:0]) : sc[7:0];
        end
    endfunction

    // Signed saturating add of two commands
    function automatic logic [7:0] sat_add(input logic [7:0] a,
            input logic [7:0] b, input logic sub);
        logic signed [9:0] s;
        s = sub ? 10'($signed(a)) - 10'($signed(b))
                : 10'($signed(a)) + 10'($signed(b));
        if (s > 10'sd127) begin
            sat_add = CMD_MAX;
        end else if (s < -10'sd127) begin
            sat_add = CMD_MIN;
        end else begin
            sat_add = s[7:0];
        end
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
    endfunction

    // ******************************************************
    // State
    // ******************************************************
    typedef struct packed {
        logic [1:0]   sw_sync;
        logic [7:0]   cmd1;
        logic [7:0]   cmd2;
        logic [9:0]   fb1;
        logic [9:0]   fb2;
        logic         armed;
        logic         acc;
        tx_state_t    st;
        logic [31:0]  period_cnt;
        logic [95:0]  snap;
        logic [4:0]   char_idx;
        logic [3:0]   bit_idx;
        logic [15:0]  bit_cnt;
        logic [9:0]   shreg;
        logic         tx;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic [7:0] rc1;
    logic [7:0] rc2;
    logic [7:0] rc3;
    logic [7:0] an1;
    logic [7:0] an2;
    logic [7:0] src1;
    logic [7:0] src2;
    logic [7:0] fin1;
    logic [7:0] fin2;
    logic       centered;
    logic       stop;
    logic [7:0] cur_byte;

    // Command path for both sources
    always_comb begin
        rc1  = pulse_to_cmd(pulse1, cal_min, cal_ctr, cal_max);
        rc2  = pulse_to_cmd(pulse2, cal_min, cal_ctr, cal_max);
        rc3  = pulse_to_cmd(pulse3, cal_min, cal_ctr, cal_max);
        an1  = shape(adc_to_cmd(ana1), deadband);
        an2  = shape(adc_to_cmd(ana2), deadband);
        src1 = analog_mode ? an1 : rc1;
        src2 = analog_mode ? an2 : rc2;
        if (mixed_mode) begin
            fin1 = sat_add(src1, src2, 1'b0);
            fin2 = sat_add(src1, src2, 1'b1);
        end else begin
            fin1 = src1;
            fin2 = src2;
        end
        // Invert switch negates, estop forces zero
        if (analog_mode && s_reg.sw_sync[1] && !switch_is_estop) begin
            fin1 = 8'(-fin1);
            fin2 = 8'(-fin2);
        end
        stop = analog_mode && s_reg.sw_sync[1] && switch_is_estop;
        centered = (ana1 >= ADC_MID - ADC_MID_TOL)
                && (ana1 <= ADC_MID + ADC_MID_TOL)
                && (ana2 >= ADC_MID - ADC_MID_TOL)
                && (ana2 <= ADC_MID + ADC_MID_TOL);
        cur_byte = s_reg.snap[95 - 8*(s_reg.char_idx >> 1) -: 8];
    end

    // Next-state logic
    always_comb begin
        s_next = s_reg;
        s_next.sw_sync = {s_reg.sw_sync[0], switch_in};
        s_next.cmd1 = (s_reg.armed && !stop) ? fin1 : 8'h00;
        s_next.cmd2 = (s_reg.armed && !stop) ? fin2 : 8'h00;
        s_next.fb1  = ana3;
        s_next.fb2  = ana4;
        // Analog mode arms only once both inputs are centered
        if (!analog_mode) begin
            s_next.armed = 1'b1;
        end else if (centered) begin
            s_next.armed = 1'b1;
        end
        // Accessory latch from channel 3
        if (ENCODER_FITTED || analog_mode || radio_lost) begin
            s_next.acc = 1'b0;
        end else if (rc3 == CMD_MAX) begin
            s_next.acc = 1'b1;
        end else if (rc3 == 8'h00) begin
            s_next.acc = 1'b0;
        end
        // Period timer restarts the string
        s_next.period_cnt = s_reg.period_cnt + 32'd1;
        if (s_reg.period_cnt >= 32'(PERIOD_CYCLES - 1)) begin
            s_next.period_cnt = 32'h0;
        end
        case (s_reg.st)
            TX_IDLE: begin
                s_next.tx = 1'b1;
                if (s_reg.period_cnt == 32'h0) begin
                    // One consistent capture of all twelve fields
                    s_next.snap = {s_reg.cmd1, s_reg.cmd2,
                                   status_fields};
                    s_next.char_idx = 5'd0;
                    s_next.st = TX_WAIT;
                end
            end
            TX_WAIT: begin
                // Load next character, or the end marker
                s_next.shreg = {1'b1, (s_reg.char_idx < 5'(N_CHARS))
                    ? hex_char(s_reg.char_idx[0] ? cur_byte[3:0]
                                                 : cur_byte[7:4])
                    : FRAME_END, 1'b0};
                s_next.bit_idx = 4'd0;
                s_next.bit_cnt = 16'h0;
                s_next.st = TX_SEND;
            end
            TX_SEND: begin
                s_next.tx = s_reg.shreg[0];
                s_next.bit_cnt = s_reg.bit_cnt + 16'd1;
                if (s_reg.bit_cnt >= 16'(BIT_CYCLES - 1)) begin
                    s_next.bit_cnt = 16'h0;
                    s_next.shreg = {1'b1, s_reg.shreg[9:1]};
                    s_next.bit_idx = s_reg.bit_idx + 4'd1;
                    if (s_reg.bit_idx == 4'd9) begin
                        s_next.char_idx = s_reg.char_idx + 5'd1;
                        s_next.st = (s_reg.char_idx >= 5'(N_CHARS))
                                  ? TX_IDLE : TX_WAIT;
                    end
                end
            end
            default: s_next.st = TX_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.st <= TX_IDLE;
            s_reg.tx <= 1'b1;
            s_reg.sw_sync <= 2'b00;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs
    assign motor_cmd1     = s_reg.cmd1;
    assign motor_cmd2     = s_reg.cmd2;
    assign feedback1      = s_reg.fb1;
    assign feedback2      = s_reg.fb2;
    assign motors_enabled = s_reg.armed;
    assign closed_loop_ok = closed_loop_req
                          && (!analog_mode || ENCODER_FITTED);
    assign accessory_out  = s_reg.acc;
    assign serial_tx      = s_reg.tx;

    // ******************************************************
    // Assertions
    // ******************************************************
    a_acc_radio_loss: assert property (@(posedge clk) disable iff (reset)
        radio_lost |=> !accessory_out) else $error("accessory on in loss");
    a_acc_encoder_off: assert property (@(posedge clk) disable iff (reset)
        ENCODER_FITTED |-> !accessory_out) else $error("acc on encoder");
    a_acc_set_max: assert property (@(posedge clk) disable iff (reset)
        (rc3 == CMD_MAX && !radio_lost && !analog_mode && !ENCODER_FITTED)
        |=> accessory_out) else $error("acc not set");
    a_arm_needs_ctr: assert property (@(posedge clk) disable iff (reset)
        analog_mode && $rose(motors_enabled) |-> $past(centered))
        else $error("armed off center");
    a_cmd_zero_unarmed: assert property (@(posedge clk) disable iff (reset)
        !motors_enabled |-> motor_cmd1 == 8'h00 && motor_cmd2 == 8'h00)
        else $error("command while disarmed");
    a_cmd_no_wrap: assert property (@(posedge clk) disable iff (reset)
        motor_cmd1 != 8'h80 && motor_cmd2 != 8'h80)
        else $error("command wrapped");
    a_rc_full_fwd: assert property (@(posedge clk) disable iff (reset)
        pulse1 >= cal_max |-> rc1 == CMD_MAX) else $error("no full fwd");
    a_rc_full_rev: assert property (@(posedge clk) disable iff (reset)
        pulse1 <= cal_min && pulse1 < cal_max |-> rc1 == CMD_MIN)
        else $error("no full rev");
    a_tx_idle_high: assert property (@(posedge clk) disable iff (reset)
        s_reg.st == TX_IDLE |=> serial_tx) else $error("line not idle");
    a_loop_gate: assert property (@(posedge clk) disable iff (reset)
        analog_mode && !ENCODER_FITTED |-> !closed_loop_ok)
        else $error("loop without encoder");
    c_acc_on: cover property (@(posedge clk) $rose(accessory_out));
    c_armed: cover property (@(posedge clk) analog_mode ##1 $rose(motors_enabled));
    c_string_start: cover property (@(posedge clk) s_reg.st == TX_IDLE ##1 s_reg.st == TX_WAIT);
endmodule

// file: tb/telemetry_logger.sv
// Telemetry logger model: decodes the 8N1 serial output into characters
`timescale 1ns/10ps
module telemetry_logger #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic clk,
    input wire logic serial_tx
);
    // ****************************************************
    // Receiver
    // ****************************************************
    logic [7:0] chars[$];
    realtime    starts[$];
    logic [7:0] sh;
    bit         in_frame = 1'b0;

    // Sample each bit at its centre, LSB first; a bad stop bit gives EE
    initial begin
        forever begin
            @(negedge serial_tx);
            if (!in_frame) starts.push_back($realtime);
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                sh[i] = serial_tx;
            end
            repeat (BIT_CYCLES) @(posedge clk);
            chars.push_back(serial_tx ? sh : 8'hEE);
            in_frame = (sh != 8'h0D); // Carriage return ends a string
        end
    end
endmodule

// file: tb/rc_analog_command_front_end_tb.sv
// Testbench: command mapping, accessory, analog start-up and telemetry
`timescale 1ns/10ps
module rc_analog_command_front_end_tb;
    import rc_front_pkg::*;
    // ****************************************************
    // Signals and instances
    // ****************************************************
    localparam int PER = 20000;
    localparam int BITC = 8;
    logic clk = 1'b0, reset = 1'b1, analog_mode = 1'b0, mixed_mode = 1'b0;
    logic closed_loop_req = 1'b0, switch_is_estop = 1'b0, switch_in = 1'b0;
    logic radio_lost = 1'b0;
    logic [2:0] deadband = 3'h1;
    logic [PW_W-1:0] cal_min = 16'h03E8, cal_ctr = 16'h05DC;
    logic [PW_W-1:0] cal_max = 16'h07D0;
    logic [PW_W-1:0] pulse1 = 16'h05DC, pulse2 = 16'h05DC, pulse3 = 16'h05DC;
    logic [ADC_W-1:0] ana1 = 10'h200, ana2 = 10'h200;
    logic [ADC_W-1:0] ana3 = 10'h155, ana4 = 10'h2AA;
    logic [79:0] status_fields = 80'h0123456789ABCDEF5A3C;
    logic signed [CMD_W-1:0] motor_cmd1, motor_cmd2;
    logic [ADC_W-1:0] feedback1, feedback2;
    logic motors_enabled, closed_loop_ok, accessory_out, serial_tx;
    int bad_count = 0, comparisons = 0, cycles = 0;

    rc_analog_command_front_end #(
        .ENCODER_FITTED(1'b0), .PERIOD_CYCLES(PER), .BIT_CYCLES(BITC)
    ) DUT (
        .clk(clk), .reset(reset), .analog_mode(analog_mode),
        .mixed_mode(mixed_mode), .closed_loop_req(closed_loop_req),
        .switch_is_estop(switch_is_estop), .switch_in(switch_in),
        .radio_lost(radio_lost), .cal_min(cal_min), .cal_ctr(cal_ctr),
        .cal_max(cal_max), .pulse1(pulse1), .pulse2(pulse2),
        .pulse3(pulse3), .ana1(ana1), .ana2(ana2), .ana3(ana3),
        .ana4(ana4), .deadband(deadband), .status_fields(status_fields),
        .motor_cmd1(motor_cmd1), .motor_cmd2(motor_cmd2),
        .feedback1(feedback1), .feedback2(feedback2),
        .motors_enabled(motors_enabled), .closed_loop_ok(closed_loop_ok),
        .accessory_out(accessory_out), .serial_tx(serial_tx)
    );
    telemetry_logger #(.BIT_CYCLES(BITC)) logger (
        .clk(clk), .serial_tx(serial_tx)
    );

    // ****************************************************
    // Clock, watchdog and helpers
    // ****************************************************
    // Clock at 250 MHz
    initial begin
        forever #2 clk = ~clk;
    end
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            bad_count++;
            conclude();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic miss(input string what);
        bad_count++;
        $display("MISMATCH at %0t: %s", $time, what);
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) miss($sformatf("byte %h, expected %h", g, e));
    endtask
    task automatic chk1(input logic g, input logic e);
        comparisons++;
        if (g !== e) miss($sformatf("flag %b, expected %b", g, e));
    endtask
    task automatic chk10(input logic [9:0] g, input logic [9:0] e);
        comparisons++;
        if (g !== e) miss($sformatf("value %h, expected %h", g, e));
    endtask
    task automatic chknum(input int g, input int e);
        comparisons++;
        if (g != e) miss($sformatf("count %0d, expected %0d", g, e));
    endtask
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_radio_map();
        logic [PW_W-1:0] pw[5] = '{16'h03E8, 16'h05DC, 16'h07D0,
                                   16'h0200, 16'hF000};
        logic [7:0] ex[5] = '{8'h81, 8'h00, 8'h7F, 8'h81, 8'h7F};
        for (int c = 0; c < 2; c++) begin
            cal_ctr = c ? 16'h0514 : 16'h05DC; // Off-centre second pass
            if (c) pw[1] = 16'h0514;
            for (int i = 0; i < 5; i++) begin
                pulse1 = pw[i];
                pulse2 = pw[4 - i];
                step(3);
                chk8(motor_cmd1, ex[i]);
                chk8(motor_cmd2, ex[4 - i]);
            end
        end
        cal_ctr = 16'h05DC;
    endtask
    task automatic t_accessory();
        pulse3 = 16'h07D0; // Receiver pulse at maximum
        step(3);
        chk1(accessory_out, 1'b1);
        pulse3 = 16'h0700;
        step(3);
        chk1(accessory_out, 1'b1);
        pulse3 = 16'h05DC;
        step(3);
        chk1(accessory_out, 1'b0);
        pulse3 = 16'h07D0;
        step(3);
        radio_lost = 1'b1;
        step(3);
        chk1(accessory_out, 1'b0);
        radio_lost = 1'b0;
    endtask
    task automatic t_telemetry();
        logic [7:0] b[12];
        int n, k;
        pulse1 = 16'h07D0;
        pulse2 = 16'h03E8;
        b[0] = 8'h7F;
        b[1] = 8'h81;
        for (int i = 0; i < 10; i++) b[i + 2] = status_fields[79 - 8 * i -: 8];
        n = logger.starts.size();
        while (logger.starts.size() < n + 2) step(1);
        k = logger.chars.size();
        status_fields = 80'hFFEEDDCCBBAA99887766; // After the snapshot
        while (logger.chars.size() < k + 25) step(1);
        for (int i = 0; i < 12; i++) begin
            chk8(logger.chars[k + 2 * i], hexc(b[i][7:4]));
            chk8(logger.chars[k + 2 * i + 1], hexc(b[i][3:0]));
        end
        chk8(logger.chars[k + 24], 8'h0D);
        while (logger.starts.size() < n + 3) step(1);
        chknum(int'(logger.starts[n + 2] - logger.starts[n + 1]), PER * 4);
    endtask
    task automatic t_analog();
        analog_mode = 1'b1;
        ana1 = 10'h3FF;
        reset = 1'b1;
        step(3);
        reset = 1'b0;
        step(4);
        chk1(motors_enabled, 1'b0);
        chk8(motor_cmd1, 8'h00);
        chk1(accessory_out, 1'b0);
        chk10(feedback1, 10'h155);
        chk10(feedback2, 10'h2AA);
        ana1 = 10'h200;
        step(4);
        chk1(motors_enabled, 1'b1);
        ana1 = 10'h3FF;
        ana2 = 10'h000;
        step(4);
        chk8(motor_cmd1, 8'h7F);
        chk8(motor_cmd2, 8'h81);
        deadband = 3'h2;
        ana1 = 10'h204;
        ana2 = 10'h1FC;
        step(4);
        chk8(motor_cmd1, 8'h00);
        chk8(motor_cmd2, 8'h00);
        mixed_mode = 1'b1;
        ana1 = 10'h3FF;
        ana2 = 10'h3FF;
        step(4);
        chk8(motor_cmd1, 8'h7F);
        chk8(motor_cmd2, 8'h00);
        closed_loop_req = 1'b1;
        step(1);
        chk1(closed_loop_ok, 1'b0);
        switch_is_estop = 1'b1;
        switch_in = 1'b1;
        step(5);
        chk8(motor_cmd1, 8'h00);
        chk8(motor_cmd2, 8'h00);
    endtask

    // Main sequence
    initial begin
        step(1);
        chk8(motor_cmd1, 8'h00);
        chk1(serial_tx, 1'b1);
        step(2);
        reset = 1'b0;
        step(1);
        chk1(motors_enabled, 1'b1);
        t_radio_map();
        t_accessory();
        t_telemetry();
        t_analog();
        conclude();
    end
endmodule
